// >>> logic/dc_drive_map.svh
// register offsets, field positions and cycle counts of the direct-drive block
// assumes 7-bit register addresses and 32-bit register data
`ifndef DC_DRIVE_MAP_SVH
`define DC_DRIVE_MAP_SVH
`define REG_GLOBAL_CFG 7'h00
`define REG_CURRENTS 7'h10
`define REG_WAIT_TIME 7'h11
`define REG_ACTUAL_POS 7'h21
`define REG_TARGET 7'h2D
`define REG_CHOPPER 7'h6C
`define REG_PWM_CFG 7'h70
`define GCFG_PWM_BIT 2
`define GCFG_DIRECT_BIT 16
`define PWMC_AUTO_BIT 18
`define PWMC_COAST_LSB 20
`define COAST_FREE 2'b01
`define SPI_LAST_BIT 6'd39
`define UART_SYNC 8'h05
`define UART_MASTER 8'hFF
`define CRC_POLY 8'h07
`define TICK_CYCLES 262144
`define UART_BIT_CYCLES 868
`define FULL_SCALE 9'h100
`define RED_MAX 8'hFF
`endif

// >>> logic/dc_drive_pkg.sv
// types shared by the direct-drive block
// constants live in dc_drive_map.svh
package dc_drive_pkg;

  typedef enum logic [1:0] {
    PH_HOLD = 2'b00,
    PH_RUN = 2'b01,
    PH_DECAY = 2'b10
  } phase_t;

  typedef struct packed {
    logic [39:0] sh;
    logic [39:0] cap;
    logic tog;
  } link_t;

  typedef struct packed {
    logic [31:0] gcfg;
    logic [31:0] currents;
    logic [31:0] pwmc;
    logic [31:0] target;
    logic [31:0] chop;
    logic [7:0] wait_time;
    logic t1, t2, tseen, s1, s2, s3, la1, la2, lb1, lb2, r1, r2;
    logic [39:0] reply;
    phase_t phase;
    logic [4:0] scale;
    logic [19:0] tick;
    logic [7:0] wcnt;
    logic [3:0] dcnt;
    logic [7:0] red;
    logic [8:0] duty_a, duty_b;
    logic [7:0] lim_a, lim_b;
    logic reg_a, reg_b, coast;
    logic rbusy;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic [2:0] ridx;
    logic [55:0] rbuf;
    logic [7:0] rcrc;
    logic tbusy;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [2:0] tbyte;
    logic [63:0] tbuf;
    logic [9:0] tsh;
  } st_t;

endpackage

// >>> logic/dc_motor_direct_drive.sv
// direct-drive control of two coil bridges with SPI and single-wire UART access
// assumes a 100 MHz mclk_in; spi_clk_in only toggles while spi_cs_n_in is low
`timescale 1ns/10ps
`include "dc_drive_map.svh"

// Behaviour
// - direct flag set: coil outputs come from target register, not commutation
// - coil A setting is target bits 8..0, coil B bits 24..16
// - in direct mode the current limit scales with the phase current: standstill in hold, motion after a step
// - direct mode ignores step for positioning and the commutation inputs
// - each coil setting is signed -255..+255, linear to full voltage
// - in pwm mode without autoscale the coil voltage runs open loop, no current sensing
// - with autoscale the limit is the phase current (standstill or motion) times pwm magnitude
// - in pwm mode with autoscale only the coil with larger magnitude is current regulated
// - when that coil hits its limit both duties shrink proportionally
// - chopper mode regulates both bridges independently
// - current phases stay active but run phase starts only on a step
// - a step raises both coils to motion current; host steps on switch-on
// - spi read: address first, data returned in the next transfer
// - uart read request is four bytes; device answers with eight bytes
module dc_motor_direct_drive
  import dc_drive_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int BIT_CYCLES = `UART_BIT_CYCLES,
  parameter logic [7:0] NODE_ADDR = 8'h00
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // spi link
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  // single-wire uart
  input wire logic uart_rx_in,
  output logic uart_tx_out,
  output logic uart_tx_oe_out,
  // motion side
  input wire logic step_in,
  input wire logic [8:0] commut_a_in,
  input wire logic [8:0] commut_b_in,
  input wire logic [31:0] actual_position_in,
  input wire logic limit_a_in,
  input wire logic limit_b_in,
  // bridge control
  output logic [8:0] coil_a_duty_out,
  output logic [8:0] coil_b_duty_out,
  output logic [7:0] coil_a_limit_out,
  output logic [7:0] coil_b_limit_out,
  output logic coil_a_reg_en_out,
  output logic coil_b_reg_en_out,
  output logic bridge_en_out,
  output logic coast_out
);

  st_t st_reg, st_next;
  link_t lk_reg, lk_next;
  logic [5:0] bit_cnt_reg;

  function automatic logic [7:0] mag(input logic [8:0] v);
    logic [8:0] a;
    a = v[8] ? 9'(-v) : v;
    mag = a[8] ? 8'hFF : a[7:0];
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c;
    for (int i = 0; i < 8; i++)
    begin
      if (x[7] ^ b[i])
        x = {x[6:0], 1'b0} ^ `CRC_POLY;
      else
        x = {x[6:0], 1'b0};
    end
    crc8 = x;
  endfunction

  function automatic logic [31:0] read_reg(input st_t s, input logic [6:0] a,
                                           input logic [31:0] pos);
    if (a == `REG_GLOBAL_CFG)
      read_reg = s.gcfg;
    else if (a == `REG_CURRENTS)
      read_reg = s.currents;
    else if (a == `REG_WAIT_TIME)
      read_reg = {24'h000000, s.wait_time};
    else if (a == `REG_ACTUAL_POS)
      read_reg = pos;
    else if (a == `REG_TARGET)
      read_reg = s.target;
    else if (a == `REG_CHOPPER)
      read_reg = s.chop;
    else if (a == `REG_PWM_CFG)
      read_reg = s.pwmc;
    else
      read_reg = 32'h00000000;
  endfunction

  // link domain: the frame counter is cleared by the select itself
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in)
  begin
    if (spi_cs_n_in)
      bit_cnt_reg <= 6'h00;
    else if (bit_cnt_reg <= `SPI_LAST_BIT)
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
  end

  always_comb
  begin
    lk_next = lk_reg;
    lk_next.sh = {lk_reg.sh[38:0], spi_mosi_in};
    if (bit_cnt_reg == `SPI_LAST_BIT)
    begin
      lk_next.cap = {lk_reg.sh[38:0], spi_mosi_in};
      lk_next.tog = ~lk_reg.tog;
    end
  end

  always_ff @(posedge spi_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  // reply word only changes between frames, so the link reads it as static
  assign spi_miso_out = (bit_cnt_reg <= `SPI_LAST_BIT) ?
                        st_reg.reply[`SPI_LAST_BIT - bit_cnt_reg] : 1'b0;
  assign spi_miso_oe_out = ~spi_cs_n_in;

  // main domain
  logic wr, tick_p, step_rise, byte_ok, direct, pwm, auto_sc, a_big, hit;
  logic [6:0] wa;
  logic [31:0] wd;
  logic [4:0] standstill_current, motion_current;
  logic [3:0] idly;
  logic [8:0] ta, tb, ka;
  logic [7:0] ma, mb, b, c;
  logic [12:0] pa, pb;
  logic [16:0] da, db;
  logic [55:0] tx7;

  always_comb
  begin
    st_next = st_reg;
    wr = 1'b0;
    wa = 7'h00;
    wd = 32'h00000000;
    byte_ok = 1'b0;
    b = st_reg.rsh;
    c = 8'h00;
    tx7 = '0;
    st_next.t1 = lk_reg.tog;
    st_next.t2 = st_reg.t1;
    st_next.s1 = step_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.la1 = limit_a_in;
    st_next.la2 = st_reg.la1;
    st_next.lb1 = limit_b_in;
    st_next.lb2 = st_reg.lb1;
    st_next.r1 = uart_rx_in;
    st_next.r2 = st_reg.r1;
    direct = st_reg.gcfg[`GCFG_DIRECT_BIT];
    pwm = st_reg.gcfg[`GCFG_PWM_BIT];
    auto_sc = st_reg.pwmc[`PWMC_AUTO_BIT];
    standstill_current = st_reg.currents[4:0];
    motion_current = st_reg.currents[12:8];
    idly = st_reg.currents[19:16];

    // spi frame handed over by toggle
    if (st_reg.t2 != st_reg.tseen)
    begin
      st_next.tseen = st_reg.t2;
      if (lk_reg.cap[39])
      begin
        wr = 1'b1;
        wa = lk_reg.cap[38:32];
        wd = lk_reg.cap[31:0];
      end
      st_next.reply = {6'h00, direct, st_reg.phase == PH_RUN,
                       read_reg(st_reg, lk_reg.cap[38:32], actual_position_in)};
    end

    // uart receiver, sampled mid-bit; deaf while our own reply is on the wire
    if (!st_reg.rbusy)
    begin
      if (!st_reg.r2 && !st_reg.tbusy)
      begin
        st_next.rbusy = 1'b1;
        st_next.rcnt = 16'(BIT_CYCLES / 2);
        st_next.rbit = 4'h0;
      end
    end
    else if (st_reg.rcnt != 16'h0000)
      st_next.rcnt = st_reg.rcnt - 16'h0001;
    else
    begin
      st_next.rcnt = 16'(BIT_CYCLES - 1);
      st_next.rbit = st_reg.rbit + 4'h1;
      if (st_reg.rbit == 4'h0 && st_reg.r2)
        st_next.rbusy = 1'b0;
      else if (st_reg.rbit == 4'h9)
      begin
        st_next.rbusy = 1'b0;
        byte_ok = 1'b1;
      end
      else if (st_reg.rbit != 4'h0)
        st_next.rsh = {st_reg.r2, st_reg.rsh[7:1]};
    end

    if (byte_ok)
    begin
      st_next.rbuf = {st_reg.rbuf[47:0], b};
      st_next.rcrc = crc8((st_reg.ridx == 3'h0) ? 8'h00 : st_reg.rcrc, b);
      st_next.ridx = st_reg.ridx + 3'h1;
      if (st_reg.ridx == 3'h0 && b != `UART_SYNC)
        st_next.ridx = 3'h0;
      else if (st_reg.ridx == 3'h3 && !st_reg.rbuf[7])
      begin
        st_next.ridx = 3'h0;
        if (b == st_reg.rcrc && st_reg.rbuf[15:8] == NODE_ADDR && !st_reg.tbusy)
        begin
          tx7 = {`UART_SYNC, `UART_MASTER, 1'b0, st_reg.rbuf[6:0],
                 read_reg(st_reg, st_reg.rbuf[6:0], actual_position_in)};
          for (int i = 6; i >= 0; i--)
            c = crc8(c, tx7[i * 8 +: 8]);
          st_next.tbuf = {tx7, c};
          st_next.tbusy = 1'b1;
          st_next.tbyte = 3'h0;
          st_next.tbit = 4'h0;
          st_next.tcnt = 16'(BIT_CYCLES - 1);
          st_next.tsh = {1'b1, `UART_SYNC, 1'b0};
        end
      end
      else if (st_reg.ridx == 3'h7)
      begin
        st_next.ridx = 3'h0;
        // spi wins if both land in the same cycle
        if (b == st_reg.rcrc && st_reg.rbuf[47:40] == NODE_ADDR && st_reg.rbuf[39] && !wr)
        begin
          wr = 1'b1;
          wa = st_reg.rbuf[38:32];
          wd = st_reg.rbuf[31:0];
        end
      end
    end

    // uart transmitter, eight frames per reply
    if (st_reg.tbusy)
    begin
      if (st_reg.tcnt != 16'h0000)
        st_next.tcnt = st_reg.tcnt - 16'h0001;
      else
      begin
        st_next.tcnt = 16'(BIT_CYCLES - 1);
        st_next.tsh = {1'b1, st_reg.tsh[9:1]};
        st_next.tbit = st_reg.tbit + 4'h1;
        if (st_reg.tbit == 4'h9)
        begin
          st_next.tbit = 4'h0;
          st_next.tbyte = st_reg.tbyte + 3'h1;
          st_next.tbuf = {st_reg.tbuf[55:0], 8'h00};
          st_next.tsh = {1'b1, st_reg.tbuf[55:48], 1'b0};
          if (st_reg.tbyte == 3'h7)
            st_next.tbusy = 1'b0;
        end
      end
    end

    if (wr)
    begin
      if (wa == `REG_GLOBAL_CFG)
        st_next.gcfg = wd;
      else if (wa == `REG_CURRENTS)
        st_next.currents = wd;
      else if (wa == `REG_WAIT_TIME)
        st_next.wait_time = wd[7:0];
      else if (wa == `REG_TARGET)
        st_next.target = wd;
      else if (wa == `REG_CHOPPER)
        st_next.chop = wd;
      else if (wa == `REG_PWM_CFG)
        st_next.pwmc = wd;
    end

    // current phases: hold, run after a step, then stepwise decay
    tick_p = st_reg.tick == 20'(TICK_CYCLES - 1);
    st_next.tick = tick_p ? 20'h00000 : st_reg.tick + 20'h00001;
    step_rise = st_reg.s2 & ~st_reg.s3;
    case (st_reg.phase)
      PH_HOLD:
        st_next.scale = standstill_current;
      PH_RUN:
      begin
        st_next.scale = motion_current;
        if (tick_p)
        begin
          if (st_reg.wcnt >= st_reg.wait_time)
          begin
            st_next.phase = PH_DECAY;
            st_next.dcnt = 4'h0;
          end
          else
            st_next.wcnt = st_reg.wcnt + 8'h01;
        end
      end
      PH_DECAY:
        if (tick_p)
        begin
          if (st_reg.dcnt >= idly)
          begin
            st_next.dcnt = 4'h0;
            if (st_reg.scale <= standstill_current)
            begin
              st_next.phase = PH_HOLD;
              st_next.scale = standstill_current;
            end
            else
              st_next.scale = st_reg.scale - 5'h01;
          end
          else
            st_next.dcnt = st_reg.dcnt + 4'h1;
        end
      default:
        st_next.phase = PH_HOLD;
    endcase
    // no step, no run phase; one step lifts both coils together
    if (step_rise)
    begin
      st_next.phase = PH_RUN;
      st_next.scale = motion_current;
      st_next.wcnt = 8'h00;
    end

    // coil settings; commutation inputs unused in direct mode
    ta = direct ? st_reg.target[8:0] : commut_a_in;
    tb = direct ? st_reg.target[24:16] : commut_b_in;
    ma = mag(ta);
    mb = mag(tb);
    a_big = ma >= mb;
    pa = 13'(ma) * 13'(st_reg.scale);
    pb = 13'(mb) * 13'(st_reg.scale);
    st_next.lim_a = pa[12:5];
    st_next.lim_b = pb[12:5];
    if (pwm)
    begin
      st_next.reg_a = auto_sc & a_big;
      st_next.reg_b = auto_sc & ~a_big;
    end
    else
    begin
      st_next.reg_a = 1'b1;
      st_next.reg_b = 1'b1;
    end
    // shared reduction tracks the larger coil's limit comparator
    hit = a_big ? st_reg.la2 : st_reg.lb2;
    if (!(pwm && auto_sc))
      st_next.red = 8'h00;
    else if (hit && st_reg.red != `RED_MAX)
      st_next.red = st_reg.red + 8'h01;
    else if (!hit && st_reg.red != 8'h00)
      st_next.red = st_reg.red - 8'h01;
    ka = `FULL_SCALE - {1'b0, st_reg.red};
    da = 17'(ma) * 17'(ka);
    db = 17'(mb) * 17'(ka);
    st_next.duty_a = ta[8] ? 9'(-{1'b0, da[15:8]}) : {1'b0, da[15:8]};
    st_next.duty_b = tb[8] ? 9'(-{1'b0, db[15:8]}) : {1'b0, db[15:8]};
    st_next.coast = pwm && standstill_current == 5'h00 &&
                    st_reg.pwmc[`PWMC_COAST_LSB +: 2] == `COAST_FREE;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign uart_tx_out = st_reg.tsh[0] | ~st_reg.tbusy;
  assign uart_tx_oe_out = st_reg.tbusy;
  assign coil_a_duty_out = st_reg.duty_a;
  assign coil_b_duty_out = st_reg.duty_b;
  assign coil_a_limit_out = st_reg.lim_a;
  assign coil_b_limit_out = st_reg.lim_b;
  assign coil_a_reg_en_out = st_reg.reg_a;
  assign coil_b_reg_en_out = st_reg.reg_b;
  assign bridge_en_out = st_reg.chop[3:0] != 4'h0;
  assign coast_out = st_reg.coast;

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence seq_step;
    st_reg.s2 && !st_reg.s3;
  endsequence

  sequence seq_hold_kept;
    st_reg.phase == PH_HOLD ##1 st_reg.phase == PH_HOLD && $stable(st_reg.currents);
  endsequence

  chk_target_coil_a: assert property (
    (direct && st_reg.red == 8'h00 && st_reg.target[8:0] != 9'h100)
      |=> coil_a_duty_out == $past(st_reg.target[8:0]))
    else $error("coil a duty does not follow target");
  chk_target_coil_b: assert property (
    (direct && st_reg.red == 8'h00 && st_reg.target[24:16] != 9'h100)
      |=> coil_b_duty_out == $past(st_reg.target[24:16]))
    else $error("coil b duty does not follow target");
  chk_hold_scale: assert property (seq_hold_kept |-> st_reg.scale == standstill_current)
    else $error("hold phase not at standstill current");
  chk_step_run: assert property (seq_step |=> st_reg.phase == PH_RUN
    && st_reg.scale == $past(motion_current))
    else $error("step did not raise current to run level");
  chk_no_step_run: assert property (
    (st_reg.phase != PH_RUN && !step_rise) |=> st_reg.phase != PH_RUN)
    else $error("run phase entered without a step");
  chk_open_loop: assert property (
    (pwm && !auto_sc) ##1 (pwm && !auto_sc) |-> !coil_a_reg_en_out && !coil_b_reg_en_out)
    else $error("current regulation active without autoscale");
  chk_one_regulated: assert property (
    (pwm && auto_sc) |=> !(coil_a_reg_en_out && coil_b_reg_en_out))
    else $error("both coils regulated in pwm mode");
  // first edge after release still shows reset values, so skip it
  chk_chop_both: assert property (
    (rst_n_in && !pwm) |=> coil_a_reg_en_out && coil_b_reg_en_out)
    else $error("chopper mode not regulating both bridges");
  chk_ratio_drop: assert property (
    (pwm && auto_sc && hit && st_reg.red != `RED_MAX) |=> st_reg.red == $past(st_reg.red) + 8'h01)
    else $error("duty reduction did not follow the limit");
  chk_reply_len: assert property ($rose(st_reg.tbusy) |-> st_reg.tbusy[*8])
    else $error("uart reply cut short");

endmodule

// >>> verification/dc_motor_direct_drive_tb.sv
// self-checking bench for the direct-drive block with a host on spi and uart
// assumes shortened tick and bit-time parameters
`timescale 1ns/10ps
`include "dc_drive_map.svh"
module dc_motor_direct_drive_tb;
  typedef struct packed {
    logic [31:0] gcfg;
    logic [31:0] pwmc;
    logic [31:0] target;
    logic [8:0] da;
    logic [8:0] db;
    logic ra;
    logic rb;
  } row_t;

  logic mclk_in, rst_n_in, step_in, limit_a_in, limit_b_in;
  logic [8:0] commut_a_in, commut_b_in, duty_a, duty_b;
  logic [31:0] actual_position_in;
  logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_oe;
  logic host_drv, uart_wire, uart_tx, uart_oe;
  logic [7:0] lim_a, lim_b, c;
  logic reg_a, reg_b, bridge_en, coast;
  logic [39:0] rx;
  logic [63:0] e;
  logic [7:0] rb [8];
  int fail_count, check_count, d;
  // autoscale off, autoscale on twice, chopper with the -256 clamp
  row_t rows [4] = '{
    '{32'h0001_0004, 32'h0, 32'h00FF_0001, 9'h001, 9'h0FF, 1'b0, 1'b0},
    '{32'h0001_0004, 32'h0004_0000, 32'h0101_01FF, 9'h1FF, 9'h101, 1'b0, 1'b1},
    '{32'h0001_0004, 32'h0004_0000, 32'h0010_0180, 9'h180, 9'h010, 1'b1, 1'b0},
    '{32'h0001_0000, 32'h0, 32'h0100_0100, 9'h101, 9'h101, 1'b1, 1'b1}};

  // single-wire line: device wins while it drives, host idles high
  assign uart_wire = uart_oe ? uart_tx : host_drv;

  dc_motor_direct_drive #(.TICK_CYCLES(16), .BIT_CYCLES(8)) u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .spi_clk_in(spi_clk), .spi_cs_n_in(spi_cs_n), .spi_mosi_in(spi_mosi),
    .spi_miso_out(spi_miso), .spi_miso_oe_out(spi_oe),
    .uart_rx_in(uart_wire), .uart_tx_out(uart_tx), .uart_tx_oe_out(uart_oe),
    .step_in(step_in), .commut_a_in(commut_a_in), .commut_b_in(commut_b_in),
    .actual_position_in(actual_position_in), .limit_a_in(limit_a_in),
    .limit_b_in(limit_b_in), .coil_a_duty_out(duty_a), .coil_b_duty_out(duty_b),
    .coil_a_limit_out(lim_a), .coil_b_limit_out(lim_b), .coil_a_reg_en_out(reg_a),
    .coil_b_reg_en_out(reg_b), .bridge_en_out(bridge_en), .coast_out(coast));

  host_link #(.BIT(8)) u_host (
    .mclk_in(mclk_in), .spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n),
    .spi_mosi_out(spi_mosi), .spi_miso_in(spi_miso), .uart_drv_out(host_drv),
    .uart_wire_in(uart_wire), .uart_oe_in(uart_oe));

  function automatic logic [7:0] lim(input logic [8:0] s, input int k);
    int m;
    m = s[8] ? 512 - int'(s) : int'(s);
    return 8'((m * k) >> 5);
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] dat);
    u_host.spi_xfer({1'b1, a, dat}, rx);
    repeat (8) @(posedge mclk_in);
  endtask

  // address frame loads the reply, the next frame shifts it out
  task automatic rd(input logic [6:0] a);
    u_host.spi_xfer({1'b0, a, 32'h0}, rx);
    repeat (8) @(posedge mclk_in);
    u_host.spi_xfer({1'b0, a, 32'h0}, rx);
    repeat (8) @(posedge mclk_in);
  endtask

  task automatic reset_vals(input string tag);
    check(tag, {duty_a, duty_b, lim_a, lim_b, reg_a, reg_b, bridge_en, coast, uart_oe}, 0);
    check(tag, {uart_tx, spi_oe}, 2'b10);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // whole run needs about 5000 cycles
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    final_report;
  end

  initial
  begin
    fail_count = 0;
    check_count = 0;
    rst_n_in = 1'b1;
    step_in = 1'b0;
    limit_a_in = 1'b0;
    limit_b_in = 1'b0;
    commut_a_in = 9'h000;
    commut_b_in = 9'h000;
    actual_position_in = 32'h1234_5678;
    // start high so the fall is a real edge for every async reset
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    reset_vals("reset");
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    // position comes from the motion side, not from a register write
    rd(`REG_ACTUAL_POS);
    check("pos read", rx, {8'h00, 32'h1234_5678});
    wr(`REG_CHOPPER, 32'h3);
    check("bridge", bridge_en, 1'b1);
    rd(`REG_CHOPPER);
    check("chop read", rx, {8'h00, 32'h0000_0003});
    commut_a_in <= 9'h055;
    commut_b_in <= 9'h1AB;
    repeat (6) @(posedge mclk_in);
    check("commut", {duty_a, duty_b}, {9'h055, 9'h1AB});
    wr(`REG_CURRENTS, 32'h0000_1F10);
    wr(`REG_WAIT_TIME, 32'h7);
    foreach (rows[i])
    begin
      wr(`REG_GLOBAL_CFG, rows[i].gcfg);
      wr(`REG_PWM_CFG, rows[i].pwmc);
      wr(`REG_TARGET, rows[i].target);
      check("duty", {duty_a, duty_b}, {rows[i].da, rows[i].db});
      check("reg", {reg_a, reg_b}, {rows[i].ra, rows[i].rb});
      check("lim", {lim_a, lim_b}, {lim(rows[i].da, 16), lim(rows[i].db, 16)});
      $display("row %0d done", i);
    end
    wr(`REG_GLOBAL_CFG, 32'h0001_0004);
    wr(`REG_PWM_CFG, 32'h0);
    wr(`REG_TARGET, 32'h00FF_0080);
    repeat (600) @(posedge mclk_in);
    check("hold lim", {lim_a, lim_b}, {8'd64, 8'd127});
    step_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    step_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    check("run lim", {lim_a, lim_b}, {lim(9'h080, 31), lim(9'h0FF, 31)});
    check("step duty", {duty_a, duty_b}, {9'h080, 9'h0FF});
    rd(`REG_ACTUAL_POS);
    check("status run", rx, {8'h03, 32'h1234_5678});
    repeat (600) @(posedge mclk_in);
    check("decay lim", {lim_a, lim_b}, {8'd64, 8'd127});
    $display("step test done");
    wr(`REG_PWM_CFG, 32'h0004_0000);
    wr(`REG_TARGET, 32'h007F_00FE);
    limit_a_in <= 1'b1;
    repeat (40) @(posedge mclk_in);
    d = int'(duty_a) - 2 * int'(duty_b);
    check("shrink", duty_a < 9'h0FE, 1'b1);
    check("ratio", d >= 0 && d <= 2, 1'b1);
    limit_a_in <= 1'b0;
    repeat (300) @(posedge mclk_in);
    check("restore", {duty_a, duty_b}, {9'h0FE, 9'h07F});
    wr(`REG_CURRENTS, 32'h0000_1F00);
    wr(`REG_PWM_CFG, 32'h0010_0000);
    check("coast on", coast, 1'b1);
    wr(`REG_PWM_CFG, 32'h0);
    check("coast off", coast, 1'b0);
    $display("limit test done");
    u_host.uart_req({8'h05, 8'h00, 8'hAD, 32'h0000_0033, 8'h00}, 8, 1'b0);
    repeat (20) @(posedge mclk_in);
    check("uart wr", duty_a, 9'h033);
    u_host.uart_req({8'h05, 8'h00, 8'hAD, 32'h0000_0044, 8'h00}, 8, 1'b1);
    repeat (20) @(posedge mclk_in);
    check("bad crc", duty_a, 9'h033);
    fork
      u_host.uart_req({8'h05, 8'h00, 8'h2D, 40'h0}, 4, 1'b0);
      for (int k = 0; k < 8; k++)
        u_host.uart_get(rb[k]);
    join
    repeat (16) @(posedge mclk_in);
    e = 64'h05FF_2D00_0000_3300;
    c = 8'h00;
    for (int k = 0; k < 7; k++)
      c = u_host.crc8(c, e[63 - 8 * k -: 8]);
    e[7:0] = c;
    check("uart rd", {rb[0], rb[1], rb[2], rb[3], rb[4], rb[5], rb[6], rb[7]}, e);
    $display("uart test done");
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    reset_vals("midrun");
    rst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    check("post reset", {reg_a, reg_b}, 2'b11);
    $display("reset test done");
    final_report;
  end
endmodule

// >>> verification/host_link.sv
// host model: spi master and single-wire uart master for the direct-drive block
// assumes BIT matches the device uart bit time in mclk cycles
`timescale 1ns/10ps
module host_link #(
  parameter int BIT = 8
)
(
  // device clock
  input wire logic mclk_in,
  // spi
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out,
  input wire logic spi_miso_in,
  // single wire
  output logic uart_drv_out,
  input wire logic uart_wire_in,
  input wire logic uart_oe_in
);
  initial
  begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b0;
    spi_mosi_out = 1'b0;
    uart_drv_out = 1'b1;
    // one rising select edge clears the frame counter before any frame
    #2;
    spi_cs_n_out = 1'b1;
  end

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    for (int j = 0; j < 8; j++)
    begin
      c = (c[7] ^ b[j]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // 40-bit frame, msb first; reply of the previous frame shifts out alongside
  task automatic spi_xfer(input logic [39:0] tx, output logic [39:0] rx);
    #1.7;
    spi_cs_n_out = 1'b0;
    for (int i = 39; i >= 0; i--)
    begin
      spi_mosi_out = tx[i];
      #3;
      rx[i] = spi_miso_in;
      spi_clk_out = 1'b1;
      #3;
      spi_clk_out = 1'b0;
    end
    #3;
    spi_cs_n_out = 1'b1;
    // stale data must not look valid
    spi_mosi_out = ~spi_mosi_out;
  endtask

  task automatic uart_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk_in);
      uart_drv_out <= f[i];
      repeat (BIT - 1) @(posedge mclk_in);
    end
  endtask

  // sync, node, address, data, crc over all preceding bytes
  task automatic uart_req(input logic [63:0] msg, input int n, input logic bad);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < n - 1; k++)
    begin
      uart_byte(msg[63 - 8 * k -: 8]);
      c = crc8(c, msg[63 - 8 * k -: 8]);
    end
    uart_byte(c ^ {7'h00, bad});
  endtask

  task automatic uart_get(output logic [7:0] b);
    int t;
    t = 0;
    while (!(uart_oe_in && !uart_wire_in) && t < 4000)
    begin
      @(posedge mclk_in);
      t++;
    end
    repeat (BIT / 2 + BIT) @(posedge mclk_in);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = uart_wire_in;
      repeat (BIT) @(posedge mclk_in);
    end
  endtask
endmodule
